// ### qec_pkg.sv
// shared constants, register map and types of the quadrature encoder counter
package qec_pkg;

    // ------------------------------------------------------------
    // clock and filter timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ          = 40_000_000; // core_clk rate
    localparam int unsigned SAMPLE_HZ_LOW   = 33_000_000; // lower documented sample rate
    localparam int unsigned SAMPLE_HZ_HIGH  = 50_000_000; // upper documented sample rate
    localparam int unsigned FILT_LONG_CLKS  = 15;         // stable samples, filter on
    localparam int unsigned FILT_SHORT_CLKS = 3;          // stable samples, filter off
    localparam int unsigned FILT_CNT_W      = 4;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W          = 8;
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_ARM         = 8'h04;
    localparam logic [7:0]  OFS_COUNT       = 8'h08;
    localparam logic [7:0]  OFS_RAW         = 8'h0C;
    localparam logic [7:0]  OFS_INPUTS      = 8'h10;

    // control register field positions
    localparam int unsigned CTRL_MODE_BIT   = 0;
    localparam int unsigned CTRL_FILT_BIT   = 1;
    localparam int unsigned CTRL_IPOL_BIT   = 2;
    localparam int unsigned CTRL_GEN_BIT    = 3;
    localparam int unsigned CTRL_GPOL_BIT   = 4;
    localparam int unsigned CTRL_HOLD_BIT   = 5;
    localparam int unsigned CTRL_W          = 6;
    localparam int unsigned ARM_BIT         = 0;

    // values after reset: quadrature, long filter, all else clear
    localparam logic [5:0]  CTRL_RESET      = 6'h02;
    localparam logic        ARM_RESET       = 1'b0;
    localparam logic [31:0] COUNT_RESET     = 32'h0000_0000;

    // AXI responses
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;

    // count step codes
    localparam logic [1:0]  STEP_NONE       = 2'h0;
    localparam logic [1:0]  STEP_UP         = 2'h1;
    localparam logic [1:0]  STEP_DOWN       = 2'h2;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic hold_zero;  // count held at zero while set
        logic gate_pol;   // 1: low gate qualifies
        logic gate_en;    // index gated by gate input
        logic index_pol;  // 1: rising index edge
        logic filter_en;  // 1: long filter
        logic count_mode; // 1: up/down on phase A
    } qec_ctrl_s;

    typedef struct packed {
        logic gate;
        logic index;
        logic phase_b;
        logic phase_a;
    } qec_pins_s;

    // register select, one-hot
    typedef enum logic [4:0] {
        SEL_CTRL   = 5'h01,
        SEL_ARM    = 5'h02,
        SEL_COUNT  = 5'h04,
        SEL_RAW    = 5'h08,
        SEL_INPUTS = 5'h10
    } qec_sel_e;

endpackage

// ### qec_filter.sv
// glitch filter for one encoder input
`timescale 1ns/1ps
`default_nettype none

module qec_filter (
    // clock and reset
    input  wire logic core_clk,
    input  wire logic resetn,
    // setting
    input  wire logic long_en,
    // data
    input  wire logic din,
    output var  logic dout
);

    logic [qec_pkg::FILT_CNT_W-1:0] cnt_q;
    logic [qec_pkg::FILT_CNT_W-1:0] cnt_d;
    logic [qec_pkg::FILT_CNT_W-1:0] last_w;
    logic                           differs_w;
    logic                           accept_w;
    logic                           dout_q;

    // ------------------------------------------------------------
    // stability check
    // ------------------------------------------------------------

    // last count before acceptance, per selected length
    assign last_w    = long_en ? qec_pkg::FILT_CNT_W'(qec_pkg::FILT_LONG_CLKS - 1)
                               : qec_pkg::FILT_CNT_W'(qec_pkg::FILT_SHORT_CLKS - 1);
    assign differs_w = din != dout_q;
    assign accept_w  = differs_w && (cnt_q >= last_w);           // [R6] [R7]
    assign cnt_d     = (!differs_w || accept_w) ? '0 : cnt_q + 1'b1;
    assign dout      = dout_q;

    // counter restarts on any bounce, so short pulses vanish
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            cnt_q  <= '0;
            dout_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            if (accept_w) begin
                dout_q <= din;
            end
        end
    end

endmodule

`default_nettype wire

// ### qec_top.sv
// quadrature encoder counter with AXI4-Lite register access
//
// Summary of operation
// R1: signed count accumulates steps and returns to zero on reset or armed index.
// R2: armed index edge zeroes count and clears arm flag together.
// R3: raw total counts every step, ignores index and hold-zero.
// R4: hold-zero keeps count at zero; only software releases it.
// R5: count mode clear selects quadrature (default), set selects up/down on A.
// R6: long filter (default) accepts a change after 15 stable samples.
// R7: short filter accepts a change after 3 stable samples.
// R8: sample clock drives filters and counters; rated 33 or 50 MHz. Here core_clk runs at 40 MHz (CLK_HZ).
// R9: index polarity true uses rising index edge, false falling; only when armed.
// R10: with gate enabled, index edges count only at qualifying gate level.
// R11: gate polarity true makes low gate qualify, false high gate.
// R12: quadrature counts every A and B edge, four per line cycle.
// R13: up/down mode counts each rising A edge, direction from B.
// R14: inputs are A, B, index and the optional gate.
// R15: A leading B counts up, B leading counts down, double change ignored.
//
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module qec_top (
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // encoder pins
    input  wire logic        enc_a,
    input  wire logic        enc_b,
    input  wire logic        enc_index,
    input  wire logic        enc_gate,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    // AXI4-Lite write response
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    // AXI4-Lite read data
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ------------------------------------------------------------
    // decode function
    // ------------------------------------------------------------

    // byte address to one-hot register select, zero when unmapped or not word aligned
    function automatic logic [4:0] reg_sel(input logic [7:0] addr);
        logic [4:0] sel;
        sel = 5'h00;
        if (addr[1:0] == 2'h0) begin
            unique case (addr)
                qec_pkg::OFS_CTRL:   sel = qec_pkg::SEL_CTRL;
                qec_pkg::OFS_ARM:    sel = qec_pkg::SEL_ARM;
                qec_pkg::OFS_COUNT:  sel = qec_pkg::SEL_COUNT;
                qec_pkg::OFS_RAW:    sel = qec_pkg::SEL_RAW;
                qec_pkg::OFS_INPUTS: sel = qec_pkg::SEL_INPUTS;
                default:             sel = 5'h00;
            endcase
        end
        return sel;
    endfunction

    // quadrature step from old and new {a,b}
    function automatic logic [1:0] quad_step(input logic [1:0] old_ab, input logic [1:0] new_ab);
        logic [1:0] step;
        step = qec_pkg::STEP_NONE;
        unique case ({old_ab, new_ab})
            4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00: step = qec_pkg::STEP_UP;
            4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00: step = qec_pkg::STEP_DOWN;
            default:                                step = qec_pkg::STEP_NONE;
        endcase
        return step;
    endfunction

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    qec_pkg::qec_pins_s pins_w;
    qec_pkg::qec_pins_s sync1_q;
    qec_pkg::qec_pins_s sync2_q;
    qec_pkg::qec_pins_s filt_w;
    qec_pkg::qec_ctrl_s ctrl_q;
    logic               arm_q;
    logic [31:0]        count_q;
    logic [31:0]        count_d;
    logic [31:0]        raw_q;
    logic [1:0]         ab_prev_q;
    logic               index_prev_q;

    logic [1:0]         quad_w;
    logic               a_rise_w;
    logic [1:0]         updn_w;
    logic [1:0]         step_w;
    logic [31:0]        delta_w;
    logic               index_edge_w;
    logic               gate_ok_w;
    logic               index_hit_w;

    logic               awready_q;
    logic               wready_q;
    logic               aw_got_q;
    logic               w_got_q;
    logic [7:0]         waddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               arready_q;
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;

    logic               aw_hs_w;
    logic               w_hs_w;
    logic               ar_hs_w;
    logic               wr_do_w;
    logic [4:0]         wsel_w;
    logic [4:0]         rsel_w;
    logic               wr_ctrl_w;
    logic               wr_arm_w;
    logic [31:0]        rd_val_w;

    // ------------------------------------------------------------
    // input synchronisers and filters
    // ------------------------------------------------------------
    assign pins_w = '{gate: enc_gate, index: enc_index, phase_b: enc_b, phase_a: enc_a}; // [R14]

    // two flops per pin before any logic looks at it
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= pins_w;
            sync2_q <= sync1_q;
        end
    end

    // one filter per input, length chosen by the filter setting
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_filt
            qec_filter u_filt (
                .core_clk (core_clk),
                .resetn   (resetn),
                .long_en  (ctrl_q.filter_en), // [R6] [R7] [R8]
                .din      (sync2_q[gi]),
                .dout     (filt_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // step and index decode
    // ------------------------------------------------------------

    // quadrature: every A and B edge is one step
    assign quad_w   = quad_step(ab_prev_q, {filt_w.phase_a, filt_w.phase_b}); // [R12] [R15]

    // up/down: rising A only, B high counts down
    assign a_rise_w = filt_w.phase_a && !ab_prev_q[1];
    assign updn_w   = !a_rise_w ? qec_pkg::STEP_NONE
                    : (filt_w.phase_b ? qec_pkg::STEP_DOWN : qec_pkg::STEP_UP); // [R13]

    assign step_w   = ctrl_q.count_mode ? updn_w : quad_w; // [R5]
    assign delta_w  = (step_w == qec_pkg::STEP_UP)   ? 32'h0000_0001
                    : (step_w == qec_pkg::STEP_DOWN) ? 32'hFFFF_FFFF
                    : 32'h0000_0000;

    // index edge of the selected polarity
    assign index_edge_w = ctrl_q.index_pol ? (filt_w.index && !index_prev_q)
                                           : (!filt_w.index && index_prev_q); // [R9]

    // gate qualifies when its level differs from the polarity bit
    assign gate_ok_w    = !ctrl_q.gate_en || (filt_w.gate != ctrl_q.gate_pol); // [R10] [R11]
    assign index_hit_w  = arm_q && index_edge_w && gate_ok_w; // [R2] [R9]

    // hold-zero and index both force zero, otherwise accumulate
    assign count_d = (ctrl_q.hold_zero || index_hit_w) ? qec_pkg::COUNT_RESET
                   : count_q + delta_w; // [R1] [R4]

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ab_prev_q    <= 2'h0;
            index_prev_q <= 1'b0;
            count_q      <= qec_pkg::COUNT_RESET;
            raw_q        <= qec_pkg::COUNT_RESET;
        end else begin
            ab_prev_q    <= {filt_w.phase_a, filt_w.phase_b};
            index_prev_q <= filt_w.index;
            count_q      <= count_d;           // [R1]
            raw_q        <= raw_q + delta_w;   // [R3]
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite handshake decode
    // ------------------------------------------------------------
    assign aw_hs_w   = s_axi_awvalid && awready_q;
    assign w_hs_w    = s_axi_wvalid && wready_q;
    assign ar_hs_w   = s_axi_arvalid && arready_q;
    assign wr_do_w   = aw_got_q && w_got_q && !bvalid_q;
    assign wsel_w    = reg_sel(waddr_q);
    assign rsel_w    = reg_sel(s_axi_araddr);
    assign wr_ctrl_w = wr_do_w && wsel_w[0] && wstrb_q[0];
    assign wr_arm_w  = wr_do_w && wsel_w[1] && wstrb_q[0];

    // read mux, fields in low bits, rest zero
    assign rd_val_w  = rsel_w[0] ? {26'h0, ctrl_q}
                     : rsel_w[1] ? {31'h0, arm_q}
                     : rsel_w[2] ? count_q
                     : rsel_w[3] ? raw_q
                     : rsel_w[4] ? {28'h0, filt_w}
                     : 32'h0000_0000;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------

    // a software write to the arm register wins over a same-cycle hit
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ctrl_q <= qec_pkg::CTRL_RESET;
            arm_q  <= qec_pkg::ARM_RESET;
        end else begin
            if (wr_ctrl_w) begin
                ctrl_q <= wdata_q[qec_pkg::CTRL_W-1:0]; // [R4] [R5]
            end
            if (wr_arm_w) begin
                arm_q <= wdata_q[qec_pkg::ARM_BIT];
            end else if (index_hit_w) begin
                arm_q <= 1'b0; // [R2]
            end
        end
    end

    // ------------------------------------------------------------
    // write channel
    // ------------------------------------------------------------

    // address and data taken in either order, response after both
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= qec_pkg::RESP_OKAY;
        end else begin
            if (aw_hs_w) begin
                aw_got_q  <= 1'b1;
                awready_q <= 1'b0;
                waddr_q   <= s_axi_awaddr;
            end else if (!aw_got_q && !bvalid_q) begin
                awready_q <= 1'b1;
            end
            if (w_hs_w) begin
                w_got_q  <= 1'b1;
                wready_q <= 1'b0;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end else if (!w_got_q && !bvalid_q) begin
                wready_q <= 1'b1;
            end
            if (wr_do_w) begin
                aw_got_q <= 1'b0;
                w_got_q  <= 1'b0;
                bvalid_q <= 1'b1;
                bresp_q  <= (wsel_w == 5'h00) ? qec_pkg::RESP_SLVERR : qec_pkg::RESP_OKAY;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------

    // data sampled at the address handshake, held until taken
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0000_0000;
            rresp_q   <= qec_pkg::RESP_OKAY;
        end else begin
            if (ar_hs_w) begin
                arready_q <= 1'b0;
                rvalid_q  <= 1'b1;
                rdata_q   <= rd_val_w;
                rresp_q   <= (rsel_w == 5'h00) ? qec_pkg::RESP_SLVERR : qec_pkg::RESP_OKAY;
            end else begin
                if (rvalid_q && s_axi_rready) begin
                    rvalid_q <= 1'b0;
                end
                if (!rvalid_q) begin
                    arready_q <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;

endmodule

`default_nettype wire

// ### qec_assertions.sv
// register bus checker for the encoder counter
`timescale 1ns/1ps
`default_nettype none

module qec_checker (
    // clock and reset
    input wire logic        core_clk,
    input wire logic        resetn,
    // write side
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read side
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    // handshake decodes
    wire ar_hs = s_axi_arvalid && s_axi_arready;
    wire aw_hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    wire bad_a = (s_axi_araddr > 8'h10) || (s_axi_araddr[1:0] != 2'h0);

    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read response dropped early");
    wr_answer_a: assert property (aw_hs |=> ##1 s_axi_bvalid) else $error("write not answered");
    rd_answer_a: assert property (ar_hs |=> s_axi_rvalid) else $error("read not answered");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken early");
    aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken early");
    bad_read_a: assert property (ar_hs && bad_a |=>
        s_axi_rresp == qec_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    good_read_a: assert property (ar_hs && !bad_a |=> s_axi_rresp == qec_pkg::RESP_OKAY)
        else $error("mapped read refused");
    b_code_a: assert property (s_axi_bvalid |->
        s_axi_bresp == qec_pkg::RESP_OKAY || s_axi_bresp == qec_pkg::RESP_SLVERR)
        else $error("bad write response");

    // main scenarios
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
    c_refuse: cover property (ar_hs && bad_a);
endmodule

bind qec_top qec_checker u_chk (
    .core_clk, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### qec_enc_model.sv
// behavioural encoder that drives the counter pins
`timescale 1ns/1ps
`default_nettype none

module qec_enc_model (
    // clock
    input  wire logic core_clk,
    // encoder pins
    output wire logic enc_a,
    output wire logic enc_b,
    output wire logic enc_index,
    output wire logic enc_gate
);
    qec_pkg::qec_pins_s pins_q = '0;

    // A, B, index and gate all driven
    assign enc_a     = pins_q.phase_a;
    assign enc_b     = pins_q.phase_b;
    assign enc_index = pins_q.index;
    assign enc_gate  = pins_q.gate;

    // change pins after an edge, then hold them
    task automatic put(input qec_pkg::qec_pins_s v, input int gap);
        @(posedge core_clk);
        pins_q <= v;
        repeat (gap) @(posedge core_clk);
    endtask

    // gray steps, A leads B when n is positive
    task automatic quad(input int n, input int gap);
        qec_pkg::qec_pins_s v;
        for (int i = 0; i < (n < 0 ? -n : n); i++) begin
            v = pins_q;
            if ((v.phase_a == v.phase_b) == (n > 0)) v.phase_a = ~v.phase_a;
            else v.phase_b = ~v.phase_b;
            put(v, gap);
        end
    endtask
endmodule
`default_nettype wire

// ### quadrature_encoder_counter_bench.sv
// self-checking bench for the encoder counter
`timescale 1ns/1ps
`default_nettype none

module quadrature_encoder_counter_bench;
    logic        core_clk = 1'b0;
    logic        resetn   = 1'b0;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata  = 32'h0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    wire logic   enc_a, enc_b, enc_index, enc_gate;
    int          ec = 0;
    int          er = 0;
    int          err_total = 0;
    int          n_checks  = 0;

    initial begin
        forever #12.5 core_clk = ~core_clk;
    end

    qec_enc_model u_enc (.core_clk, .enc_a, .enc_b, .enc_index, .enc_gate);

    qec_top u_dut (.core_clk, .resetn, .enc_a, .enc_b, .enc_index, .enc_gate,
        .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready);

    // ----------------------------------------
    // bus and compare tasks
    // ----------------------------------------
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tmo;
        err_total++;
        $display("mismatch bus answer expected 1 seen 0");
        final_report();
    endtask

    // channels and bready up together, each released when taken
    task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] x);
        int i;
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (i == 50) tmo();
        chk("bresp", {30'h0, x}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp,
                        input logic [1:0] x);
        int i;
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (i == 50) tmo();
        chk("rresp", {30'h0, x}, {30'h0, s_axi_rresp});
        chk(nm, exp, s_axi_rdata);
        s_axi_rready <= 1'b0;
    endtask

    task automatic cr;
        rchk("count", qec_pkg::OFS_COUNT, ec, 2'h0);
        rchk("raw", qec_pkg::OFS_RAW, er, 2'h0);
    endtask

    task automatic move(input int n, input int gap);
        u_enc.quad(n, gap);
        ec += n;
        er += n;
    endtask

    // phase A pulse of len+1 cycles with B set first
    task automatic pulse(input int len, input logic b, input int d);
        u_enc.put({2'b00, b, 1'b0}, 25);
        u_enc.put({2'b00, b, 1'b1}, len);
        u_enc.put({2'b00, b, 1'b0}, 25);
        ec += d;
        er += d;
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset;
        rchk("ctrl", qec_pkg::OFS_CTRL, 32'h0000_0002, 2'h0);
        rchk("arm", qec_pkg::OFS_ARM, 32'h0, 2'h0);
        cr();
        rchk("unmapped", 8'h14, 32'h0, 2'h2);
        wreg(8'h14, 32'hFFFF_FFFF, 2'h2);
        $display("test reset done");
    endtask

    task automatic t_quad;
        move(4, 25);
        cr();
        move(-6, 25);
        cr();
        u_enc.put(u_enc.pins_q ^ 4'h3, 25);
        cr();
        u_enc.put(u_enc.pins_q ^ 4'h3, 25);
        cr();
        $display("test quadrature done");
    endtask

    task automatic t_filt;
        wreg(qec_pkg::OFS_CTRL, 32'h0000_0003, 2'h0);
        pulse(13, 1'b0, 0);
        cr();
        pulse(14, 1'b0, 1);
        cr();
        pulse(14, 1'b1, -1);
        cr();
        wreg(qec_pkg::OFS_CTRL, 32'h0000_0001, 2'h0);
        pulse(1, 1'b0, 0);
        cr();
        pulse(2, 1'b0, 1);
        cr();
        $display("test filter done");
    endtask

    task automatic ip(input logic g, input logic i);
        u_enc.put({g, i, u_enc.pins_q[1:0]}, 8);
    endtask

    task automatic t_index;
        logic [7:0] cv [6] = '{8'h04, 8'h0C, 8'h0C, 8'h1C, 8'h1C, 8'h00};
        logic       gv [6] = '{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
        logic       qv [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        for (int k = 0; k < 6; k++) begin
            wreg(qec_pkg::OFS_CTRL, {24'h0, cv[k]}, 2'h0);
            ip(gv[k], 1'b0);
            move(1, 8);
            wreg(qec_pkg::OFS_ARM, 32'h1, 2'h0);
            ip(gv[k], 1'b1);
            if (qv[k] && cv[k][2]) ec = 0;
            cr();
            ip(gv[k], 1'b0);
            if (qv[k]) ec = 0;
            cr();
            rchk("arm", qec_pkg::OFS_ARM, {31'h0, !qv[k]}, 2'h0);
        end
        $display("test index done");
    endtask

    task automatic t_hold;
        wreg(qec_pkg::OFS_CTRL, 32'h0000_0020, 2'h0);
        ec = 0;
        cr();
        move(2, 8);
        ec = 0;
        cr();
        wreg(qec_pkg::OFS_CTRL, 32'h0, 2'h0);
        move(1, 8);
        cr();
        $display("test hold done");
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (2) @(posedge core_clk);
        t_reset();
        t_quad();
        t_filt();
        t_index();
        t_hold();
        final_report();
    end
endmodule
`default_nettype wire
